// file: inc/ris_defines.vh
// register offsets, field positions and error codes of the instance-select register bank
// assumes a 32-bit wishbone slave decoding byte addresses
`ifndef RIS_DEFINES_VH
`define RIS_DEFINES_VH
// byte offsets
`define RIS_OFF_MAIN_ID 8'h00
`define RIS_OFF_CUSTOM_ID 8'h04
`define RIS_OFF_PRI_ID 8'h08
`define RIS_OFF_CAP_ID 8'h0C
`define RIS_OFF_POR_ID 8'h10
`define RIS_OFF_MON_ID 8'h14
`define RIS_OFF_STMON_ID 8'h18
`define RIS_OFF_PART_SEL 8'h20
`define RIS_OFF_MON_SEL 8'h24
`define RIS_OFF_ERR_STAT 8'h28
`define RIS_OFF_CFG_COMMON 8'h30
`define RIS_OFF_CFG_CAP 8'h34
`define RIS_OFF_CFG_POR 8'h38
`define RIS_OFF_CFG_PRI 8'h3C
`define RIS_OFF_MON_CFG 8'h40
// main id fields
`define RIS_MAIN_MAX_LSB 16
`define RIS_MAIN_SEL_PRESENT 24
`define RIS_MAIN_NO_CUST_MON 26
`define RIS_MAIN_NO_CUST_PART 27
`define RIS_MAIN_MON 28
`define RIS_MAIN_CUST_ID 29
`define RIS_MAIN_PRI 30
`define RIS_MAIN_BW 31
`define RIS_MAIN_POR 0
`define RIS_MAIN_CAP 1
// selector fields
`define RIS_SEL_INST_LSB 24
`define RIS_SEL_PART_W 16
// monitor id fields
`define RIS_MON_BW 30
`define RIS_MON_ST 31
// storage monitor id fields
`define RIS_STMON_RO 30
`define RIS_STMON_CAPT 31
// priority id fields
`define RIS_PRI_DS_PRESENT 16
`define RIS_PRI_DS_W_LSB 20
// error codes
`define RIS_ERR_UNDEF_INST 4'h8
`define RIS_ERR_NO_CONTROL 4'h9
`define RIS_ERR_UNDEF_MON 4'hA
`define RIS_ERR_NO_MONITOR 4'hB
`define RIS_ERR_CODE_LSB 24
`endif

// file: hw/ris_inst_caps.v
// capability lookup: per-instance feature flags and widths for one instance index
// assumes callers feed an instance index on the bank's clock; purely combinational
`timescale 1ns/10ps
`default_nettype none
module ris_inst_caps #(
  parameter INST_BITS = 2,
  parameter INST_MAX = 2
) (
  // selection
  input wire [INST_BITS-1:0] instance_index,
  // capabilities
  output reg defined,
  output reg capacity_part_present,
  output reg portion_part_present,
  output reg priority_part_present,
  output reg bandwidth_part_present,
  output reg custom_id_present,
  output reg bandwidth_usage_monitor_present,
  output reg storage_usage_monitor_present,
  output reg storage_monitor_read_only,
  output reg storage_capture_present,
  output reg downstream_priority_present,
  output reg [3:0] downstream_priority_width,
  output reg [5:0] capacity_max_width,
  output reg [15:0] portion_bitmap_width,
  output reg [15:0] monitor_count
);
  // instance 0 is the primary cache with common controls; 1 is a bandwidth port; 2 is unassigned
  always @* begin
    defined = 1'b0;
    capacity_part_present = 1'b0;
    portion_part_present = 1'b0;
    priority_part_present = 1'b0;
    bandwidth_part_present = 1'b0;
    custom_id_present = 1'b0;
    bandwidth_usage_monitor_present = 1'b0;
    storage_usage_monitor_present = 1'b0;
    storage_monitor_read_only = 1'b0;
    storage_capture_present = 1'b0;
    downstream_priority_present = 1'b0;
    downstream_priority_width = 4'h0;
    capacity_max_width = 6'h00;
    portion_bitmap_width = 16'h0000;
    monitor_count = 16'h0000;
    if (instance_index == {INST_BITS{1'b0}}) begin
      defined = 1'b1;
      capacity_part_present = 1'b1;
      portion_part_present = 1'b1;
      priority_part_present = 1'b1;
      custom_id_present = 1'b1;
      storage_usage_monitor_present = 1'b1;
      storage_capture_present = 1'b1;
      downstream_priority_present = 1'b1;
      downstream_priority_width = 4'h4;
      capacity_max_width = 6'h08;
      portion_bitmap_width = 16'h0010;
      monitor_count = 16'h0004;
    end else if (instance_index == {{(INST_BITS-1){1'b0}}, 1'b1} && INST_MAX >= 1) begin
      defined = 1'b1;
      portion_part_present = 1'b1;
      bandwidth_part_present = 1'b1;
      bandwidth_usage_monitor_present = 1'b1;
      storage_usage_monitor_present = 1'b1;
      storage_monitor_read_only = 1'b1;
      portion_bitmap_width = 16'h0008;
      monitor_count = 16'h0002;
    end
  end
endmodule
`default_nettype wire

// file: hw/ris_cfg_store.v
// one configuration word per (instance, partition, kind) slot, written and read by index
// assumes a single clock and writes qualified by the caller
`timescale 1ns/10ps
`default_nettype none
module ris_cfg_store #(
  parameter AW = 6,
  parameter DW = 32
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // access
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire [3:0] sel,
  output wire [DW-1:0] rdata
);
  reg [DW-1:0] mem_ff [0:(1<<AW)-1];
  integer i;
  integer b;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem_ff[i] <= {DW{1'b0}};
      end
    end else if (we) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          mem_ff[addr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end
  assign rdata = mem_ff[addr];
endmodule
`default_nettype wire

// file: hw/ris_bank.v
// register bank with resource-instance selection for a memory system component
// assumes a classic wishbone master on clk; one cycle to ack
//
// Operation
// - instance select advertised by present flag one
// - each resource owns a distinct instance index
// - report highest defined index in max field; code reports INST_MAX (2), an unassigned index
// - some indices up to max may be unassigned
// - primary resource sits at instance zero
// - partition select index steers id and config
// - selection persists until selector is rewritten
// - common controls reachable only at index zero
// - single instance attaches everything to zero
// - missing control access may report code nine
// - id fields follow the selected instance
// - widths and monitor fields vary per instance
// - main id flags read zero when absent
// - two flags mark custom id contents empty
// - custom id register follows selected instance
// - monitor id flags bandwidth and storage monitors
// - downstream width ignored when not present
// - monitors selected with the same instance index
// - id registers never encode resource mapping
// - undefined index reads zero flags, no error
// - indices above the maximum are undefined
// - only implemented index bits are decoded
// - monitor select index steers monitor registers
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ris_defines.vh"
module ris_bank #(
  parameter INST_BITS = 2,
  parameter INST_MAX = 2,
  parameter PART_BITS = 4,
  parameter [31:0] CUSTOM_ID_VALUE = 32'h00C0FFEE
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // selected instance toward the resources
  output reg [INST_BITS-1:0] part_instance_o,
  output reg [PART_BITS-1:0] part_id_o,
  output reg [INST_BITS-1:0] mon_instance_o
);
  // max index at full width so the field gets an explicit cut
  localparam [31:0] INST_MAX_W = INST_MAX;
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [INST_BITS-1:0] part_inst_ff;
  reg [PART_BITS-1:0] part_id_ff;
  reg [INST_BITS-1:0] mon_inst_ff;
  reg [3:0] err_code_ff;
  reg [INST_BITS-1:0] err_inst_ff;
  reg [31:0] nxt_dat;
  reg nxt_err;
  reg [3:0] nxt_code;
  reg common_ff;

  wire req = wb_cyc_i & wb_stb_i & (state_ff == ST_IDLE);
  wire wr = req & wb_we_i;

  // decode only the implemented index bits
  wire [INST_BITS-1:0] wr_inst = wb_dat_i[`RIS_SEL_INST_LSB +: INST_BITS];
  wire [PART_BITS-1:0] wr_part = wb_dat_i[PART_BITS-1:0];

  // capabilities of the partition-selected instance
  wire p_def, p_cap, p_por, p_pri, p_bw, p_cid, p_mbw, p_mst, p_ro, p_capt, p_dsp;
  wire [3:0] p_dsw;
  wire [5:0] p_cmax;
  wire [15:0] p_pbw;
  wire [15:0] p_nmon;
  ris_inst_caps #(.INST_BITS(INST_BITS), .INST_MAX(INST_MAX)) u_pcaps (
    .instance_index(part_inst_ff),
    .defined(p_def),
    .capacity_part_present(p_cap),
    .portion_part_present(p_por),
    .priority_part_present(p_pri),
    .bandwidth_part_present(p_bw),
    .custom_id_present(p_cid),
    .bandwidth_usage_monitor_present(p_mbw),
    .storage_usage_monitor_present(p_mst),
    .storage_monitor_read_only(p_ro),
    .storage_capture_present(p_capt),
    .downstream_priority_present(p_dsp),
    .downstream_priority_width(p_dsw),
    .capacity_max_width(p_cmax),
    .portion_bitmap_width(p_pbw),
    .monitor_count(p_nmon)
  );

  // monitor-select instance capabilities
  wire m_def, m_mbw, m_mst;
  ris_inst_caps #(.INST_BITS(INST_BITS), .INST_MAX(INST_MAX)) u_mcaps (
    .instance_index(mon_inst_ff),
    .defined(m_def),
    .capacity_part_present(),
    .portion_part_present(),
    .priority_part_present(),
    .bandwidth_part_present(),
    .custom_id_present(),
    .bandwidth_usage_monitor_present(m_mbw),
    .storage_usage_monitor_present(m_mst),
    .storage_monitor_read_only(),
    .storage_capture_present(),
    .downstream_priority_present(),
    .downstream_priority_width(),
    .capacity_max_width(),
    .portion_bitmap_width(),
    .monitor_count()
  );

  // index above the maximum is undefined
  wire p_valid = p_def && (part_inst_ff <= INST_MAX);
  wire m_valid = m_def && (mon_inst_ff <= INST_MAX);

  // config slots keyed by instance and partition
  wire is_cap = (wb_adr_i == `RIS_OFF_CFG_CAP);
  wire is_por = (wb_adr_i == `RIS_OFF_CFG_POR);
  wire is_pri = (wb_adr_i == `RIS_OFF_CFG_PRI);
  wire is_mcfg = (wb_adr_i == `RIS_OFF_MON_CFG);
  wire [1:0] cfg_kind = is_por ? 2'h1 : (is_pri ? 2'h2 : 2'h0);
  wire part_ok = (is_cap & p_cap) | (is_por & p_por) | (is_pri & p_pri);
  wire mon_ok = m_mbw | m_mst;
  wire [INST_BITS+PART_BITS+1:0] cfg_addr = {part_inst_ff, part_id_ff, cfg_kind};
  wire [INST_BITS+PART_BITS+1:0] mon_addr = {mon_inst_ff, {PART_BITS{1'b0}}, 2'h3};
  wire [INST_BITS+PART_BITS+1:0] st_addr = is_mcfg ? mon_addr : cfg_addr;
  wire st_we = wr & ((is_mcfg & m_valid & mon_ok) | (~is_mcfg & p_valid & part_ok));
  wire [31:0] st_rdata;
  ris_cfg_store #(.AW(INST_BITS+PART_BITS+2), .DW(32)) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(st_we),
    .addr(st_addr),
    .wdata(wb_dat_i),
    .sel(wb_sel_i),
    .rdata(st_rdata)
  );

  // common control only at instance zero
  wire common_ok = (part_inst_ff == {INST_BITS{1'b0}});

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (wb_cyc_i & wb_stb_i) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // read data and error classification
  always @* begin
    nxt_dat = 32'h00000000;
    nxt_err = 1'b0;
    nxt_code = 4'h0;
    case (wb_adr_i)
      `RIS_OFF_MAIN_ID: begin
        // selection always advertised; max always reported
        nxt_dat[`RIS_MAIN_SEL_PRESENT] = 1'b1;
        nxt_dat[`RIS_MAIN_MAX_LSB +: INST_BITS] = INST_MAX_W[INST_BITS-1:0];
        // flags gated by defined instance, no error
        nxt_dat[`RIS_MAIN_MON] = p_valid & (p_mbw | p_mst);
        nxt_dat[`RIS_MAIN_CUST_ID] = p_valid & p_cid;
        nxt_dat[`RIS_MAIN_PRI] = p_valid & p_pri;
        nxt_dat[`RIS_MAIN_BW] = p_valid & p_bw;
        nxt_dat[`RIS_MAIN_POR] = p_valid & p_por;
        nxt_dat[`RIS_MAIN_CAP] = p_valid & p_cap;
        // custom id holds no monitors or partitioning
        nxt_dat[`RIS_MAIN_NO_CUST_MON] = p_valid;
        nxt_dat[`RIS_MAIN_NO_CUST_PART] = p_valid;
      end
      `RIS_OFF_CUSTOM_ID: begin
        // content follows selected instance
        nxt_dat = (p_valid & p_cid) ? (CUSTOM_ID_VALUE ^ {{(32-INST_BITS){1'b0}}, part_inst_ff}) : 32'h00000000;
      end
      `RIS_OFF_PRI_ID: begin
        // width forced to zero when downstream priority absent
        nxt_dat[`RIS_PRI_DS_PRESENT] = p_valid & p_pri & p_dsp;
        nxt_dat[`RIS_PRI_DS_W_LSB +: 4] = (p_valid & p_pri & p_dsp) ? p_dsw : 4'h0;
      end
      `RIS_OFF_CAP_ID: begin
        nxt_dat[5:0] = (p_valid & p_cap) ? p_cmax : 6'h00;
      end
      `RIS_OFF_POR_ID: begin
        nxt_dat[15:0] = (p_valid & p_por) ? p_pbw : 16'h0000;
      end
      `RIS_OFF_MON_ID: begin
        // monitor id follows the partition selector
        nxt_dat[`RIS_MON_BW] = p_valid & p_mbw;
        nxt_dat[`RIS_MON_ST] = p_valid & p_mst;
      end
      `RIS_OFF_STMON_ID: begin
        if (p_valid & p_mst) begin
          nxt_dat[15:0] = p_nmon;
          nxt_dat[`RIS_STMON_RO] = p_ro;
          nxt_dat[`RIS_STMON_CAPT] = p_capt;
        end
      end
      `RIS_OFF_PART_SEL: begin
        nxt_dat[`RIS_SEL_INST_LSB +: INST_BITS] = part_inst_ff;
        nxt_dat[PART_BITS-1:0] = part_id_ff;
      end
      `RIS_OFF_MON_SEL: begin
        nxt_dat[`RIS_SEL_INST_LSB +: INST_BITS] = mon_inst_ff;
      end
      `RIS_OFF_ERR_STAT: begin
        nxt_dat[`RIS_ERR_CODE_LSB +: 4] = err_code_ff;
        nxt_dat[INST_BITS-1:0] = err_inst_ff;
      end
      `RIS_OFF_CFG_COMMON: begin
        if (common_ok) begin
          nxt_dat[0] = common_ff;
        end else begin
          nxt_code = `RIS_ERR_NO_CONTROL;
        end
      end
      `RIS_OFF_CFG_CAP, `RIS_OFF_CFG_POR, `RIS_OFF_CFG_PRI: begin
        if (!p_valid) begin
          nxt_code = `RIS_ERR_UNDEF_INST;
        end else if (!part_ok) begin
          nxt_code = `RIS_ERR_NO_CONTROL;
        end else begin
          nxt_dat = st_rdata;
        end
      end
      `RIS_OFF_MON_CFG: begin
        if (!m_valid) begin
          nxt_code = `RIS_ERR_UNDEF_MON;
        end else if (!mon_ok) begin
          nxt_code = `RIS_ERR_NO_MONITOR;
        end else begin
          nxt_dat = st_rdata;
        end
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      part_inst_ff <= {INST_BITS{1'b0}};
      part_id_ff <= {PART_BITS{1'b0}};
      mon_inst_ff <= {INST_BITS{1'b0}};
      err_code_ff <= 4'h0;
      err_inst_ff <= {INST_BITS{1'b0}};
      common_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wb_ack_o <= req & ~nxt_err;
      wb_err_o <= req & nxt_err;
      wb_dat_o <= (req & ~wb_we_i) ? nxt_dat : 32'h00000000;
      // selector takes effect at the ack edge, steering the next access
      if (wr && wb_adr_i == `RIS_OFF_PART_SEL) begin
        if (wb_sel_i[3]) begin
          part_inst_ff <= wr_inst;
        end
        if (wb_sel_i[0]) begin
          part_id_ff <= wr_part;
        end
      end
      if (wr && wb_adr_i == `RIS_OFF_MON_SEL && wb_sel_i[3]) begin
        mon_inst_ff <= wr_inst;
      end
      if (wr && wb_adr_i == `RIS_OFF_CFG_COMMON && common_ok && wb_sel_i[0]) begin
        common_ff <= wb_dat_i[0];
      end
      // record configuration errors; id reads never record
      if (wr && wb_adr_i == `RIS_OFF_ERR_STAT) begin
        err_code_ff <= 4'h0;
      end else if (req && nxt_code != 4'h0) begin
        err_code_ff <= nxt_code;
        err_inst_ff <= is_mcfg ? mon_inst_ff : part_inst_ff;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      part_instance_o <= {INST_BITS{1'b0}};
      part_id_o <= {PART_BITS{1'b0}};
      mon_instance_o <= {INST_BITS{1'b0}};
    end else begin
      part_instance_o <= part_inst_ff;
      part_id_o <= part_id_ff;
      mon_instance_o <= mon_inst_ff;
    end
  end
endmodule
`default_nettype wire

// file: test/rsel_bank_monitor.sv
// checker for the instance-select register bank, watching its ports only
// assumes single wishbone requests with one idle cycle between them
`timescale 1ns/10ps
`default_nettype none
module ris_bank_monitor #(
  parameter INST_BITS = 2,
  parameter INST_MAX = 2,
  parameter PART_BITS = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  // selection
  input wire [INST_BITS-1:0] part_instance_o,
  input wire [PART_BITS-1:0] part_id_o,
  input wire [INST_BITS-1:0] mon_instance_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire wr_part = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h20;
  wire wr_mon = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h24;
  reg [INST_BITS-1:0] inst_ff;
  reg [PART_BITS-1:0] pid_ff;
  reg [INST_BITS-1:0] mon_ff;
  // last index and partition accepted over the bus
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inst_ff <= '0;
      pid_ff <= '0;
      mon_ff <= '0;
    end else begin
      if (wr_part && wb_ack_o) begin
        inst_ff <= wb_dat_i[24 +: INST_BITS];
        pid_ff <= wb_dat_i[PART_BITS-1:0];
      end
      if (wr_mon && wb_ack_o)
        mon_ff <= wb_dat_i[24 +: INST_BITS];
    end
  end
  sequence s_main_read;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  endsequence
  sequence s_part_write;
    wr_part && wb_ack_o;
  endsequence
  property p_sel_follow;
    s_part_write |=> ##[0:1] (part_instance_o == inst_ff && part_id_o == pid_ff);
  endproperty
  property p_sel_hold;
    ($changed(part_instance_o) || $changed(part_id_o)) |-> $past(wr_part, 1) || $past(wr_part, 2) || $past(wr_part, 3);
  endproperty
  property p_mon_follow;
    wr_mon && wb_ack_o |=> ##[0:1] mon_instance_o == mon_ff;
  endproperty
  property p_mon_hold;
    $changed(mon_instance_o) |-> $past(wr_mon, 1) || $past(wr_mon, 2) || $past(wr_mon, 3);
  endproperty
  property p_answer;
    $rose(wb_stb_i) && wb_cyc_i |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endproperty
  property p_present;
    s_main_read |-> wb_dat_o[24];
  endproperty
  property p_max;
    s_main_read |-> wb_dat_o[17:16] == INST_MAX;
  endproperty
  property p_undef_zero;
    s_main_read ##0 part_instance_o >= 2 |-> wb_dat_o[31:28] == 4'h0 && wb_dat_o[1:0] == 2'h0;
  endproperty
  property p_inst_one;
    s_main_read ##0 part_instance_o == 1 |-> wb_dat_o[31] && !wb_dat_o[30] && !wb_dat_o[1] && wb_dat_o[0];
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("partition selection output wrong");
  a_sel_hold: assert property (p_sel_hold) else $error("partition selection changed unasked");
  a_mon_follow: assert property (p_mon_follow) else $error("monitor selection output wrong");
  a_mon_hold: assert property (p_mon_hold) else $error("monitor selection changed unasked");
  a_answer: assert property (p_answer) else $error("bus answer not one single cycle");
  a_present: assert property (p_present) else $error("select present flag low");
  a_max: assert property (p_max) else $error("index max field wrong");
  a_undef_zero: assert property (p_undef_zero) else $error("undefined instance flags not zero");
  a_inst_one: assert property (p_inst_one) else $error("instance one flags wrong");
endmodule
bind ris_bank ris_bank_monitor #(.INST_BITS(INST_BITS), .INST_MAX(INST_MAX), .PART_BITS(PART_BITS)) u_mon (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .part_instance_o(part_instance_o),
  .part_id_o(part_id_o), .mon_instance_o(mon_instance_o));
`default_nettype wire

// file: test/resource_instance_selector_test.sv
// self-checking bench for the instance-select register bank
// assumes the bank answers every wishbone request with ack or err
`timescale 1ns/10ps
`default_nettype none
module resource_instance_selector_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic [1:0] part_instance_o;
  logic [3:0] part_id_o;
  logic [1:0] mon_instance_o;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] d;
  logic e;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 32'h0287;
  int k;
  ris_bank #(.INST_BITS(2), .INST_MAX(2), .PART_BITS(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .part_instance_o(part_instance_o),
    .part_id_o(part_id_o), .mon_instance_o(mon_instance_o));
  always #50 clk = ~clk;
  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  // one classic cycle, then one idle cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      fail_count++;
      final_report();
    end
    @(posedge clk);
  endtask
  // unused upper index bits carry noise
  task automatic sel(input logic [1:0] inst, input logic [3:0] pid);
    logic [31:0] junk;
    junk = $random(seed);
    xfer(1'b1, 8'h20, {junk[31:26], inst, 20'h0, pid});
  endtask
  task automatic errcase(input logic [1:0] inst, input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b1, 8'h28, 32'h0);
    sel(inst, 4'h3);
    xfer(1'b1, adr, $random(seed));
    check("cfg_err", {31'h0, e}, 32'h0);
    xfer(1'b0, 8'h28, 32'h0);
    check("err_stat", q & 32'h0F000003, exp);
    xfer(1'b0, adr, 32'h0);
    check("cfg_read", q, 32'h0);
  endtask
  function automatic logic [31:0] exp_id(input logic [7:0] a, input logic [1:0] i);
    logic [31:0] v[3];
    case (a)
      8'h00: v = '{32'h7D020003, 32'h9D020001, 32'h01020000};
      8'h14: v = '{32'h80000000, 32'hC0000000, 32'h0};
      default: v = '{32'h80000000, 32'h40000000, 32'h0};
    endcase
    exp_id = (i > 2'h1) ? v[2] : v[i];
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      sel(k[1:0], r[3:0]);
      check("part_out", {26'h0, part_instance_o, part_id_o}, {26'h0, k[1:0], r[3:0]});
      xfer(1'b0, 8'h00, 32'h0);
      check("main_id", q & 32'hFD030003, exp_id(8'h00, k[1:0]));
      xfer(1'b0, 8'h14, 32'h0);
      check("mon_id", q & 32'hC0000000, exp_id(8'h14, k[1:0]));
      xfer(1'b0, 8'h18, 32'h0);
      check("stmon_id", q & 32'hC0000000, exp_id(8'h18, k[1:0]));
    end
    xfer(1'b0, 8'h28, 32'h0);
    check("no_err", q & 32'h0F000000, 32'h0);
    r = $random(seed);
    d = $random(seed);
    sel(2'h0, 4'h5);
    xfer(1'b0, 8'h04, 32'h0);
    check("custom_id", q, 32'h00C0FFEE);
    xfer(1'b0, 8'h08, 32'h0);
    check("pri_id", q & 32'h00F10000, 32'h00410000);
    xfer(1'b1, 8'h38, r);
    sel(2'h1, 4'h5);
    xfer(1'b1, 8'h38, d);
    sel(2'h0, 4'h5);
    xfer(1'b0, 8'h38, 32'h0);
    check("por_cfg0", q, r);
    xfer(1'b1, 8'h34, d);
    xfer(1'b0, 8'h34, 32'h0);
    check("cap_cfg0", q, d);
    xfer(1'b0, 8'h38, 32'h0);
    check("por_cfg0_again", q, r);
    sel(2'h1, 4'h5);
    xfer(1'b0, 8'h38, 32'h0);
    check("por_cfg1", q, d);
    errcase(2'h1, 8'h34, 32'h09000001);
    errcase(2'h1, 8'h30, 32'h09000001);
    errcase(2'h3, 8'h34, 32'h08000003);
    sel(2'h0, 4'h3);
    xfer(1'b1, 8'h30, 32'h1);
    xfer(1'b0, 8'h30, 32'h0);
    check("common", q & 32'h1, 32'h1);
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      xfer(1'b1, 8'h24, {r[31:26], k[1:0], 24'h0});
      check("mon_out", {30'h0, mon_instance_o}, {30'h0, k[1:0]});
      xfer(1'b0, 8'h14, 32'h0);
      check("mon_id_sel", q & 32'hC0000000, exp_id(8'h14, 2'h0));
    end
    xfer(1'b0, 8'h2C, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("sel_reset", {26'h0, part_instance_o, part_id_o}, 32'h0);
    xfer(1'b0, 8'h00, 32'h0);
    check("main_reset", q & 32'hFD030003, exp_id(8'h00, 2'h0));
    final_report();
  end
endmodule
`default_nettype wire
